// ==== verilog/pcfgs_top.sv ====
// pci configuration identifier and command/status registers
`timescale 1ns/10ps
`default_nettype none
module pcfgs_top
  import pcfgs_pkg::*;
(
  input wire logic CORE_CLK_I,        // pci clock, 40 MHz
  input wire logic NRST_I,            // global reset, active low
  input wire logic PCI_NRST_I,        // pci reset, synchronous, active low
  input wire pcfgs_acc_t CFG_ACC_I,   // configuration access
  input wire pcfgs_evt_t EVT_I,       // status event pulses
  input wire logic ID_LOAD_I,         // load identifier from eeprom
  input wire logic [31:0] ID_DATA_I,  // identifier load value
  output logic [31:0] CFG_RDATA_O,    // read data, registered
  output logic SYSTEM_ERROR_ENABLE_O,             // system error may be driven
  output logic PERR_EN_O,             // parity error pin may be driven
  output logic [5:0] STAT_IRQ_O       // per-flag interrupt requests
);
  //==========================================================================
  // decode
  logic sel_id;
  logic sel_cs;
  logic wr_cs;
  logic [15:0] dev_id;
  logic [15:0] ven_id;
  logic system_error_enable;
  logic par_resp;
  logic dpe, sserr, rma, rta, sta, mdp;
  logic [31:0] next_rdata;
  logic [31:0] cs_word;

  // byte-lane aware write-one-to-clear helper
  function automatic logic w1c(input logic wr, input logic [3:0] be,
                               input logic [31:0] d, input int b);
    w1c = wr && be[b / 8] && d[b];
  endfunction : w1c

  assign sel_id = (CFG_ACC_I.addr == PCFGS_OFS_IDENT);
  assign sel_cs = (CFG_ACC_I.addr == PCFGS_OFS_CMDSTAT);
  assign wr_cs = CFG_ACC_I.wr && sel_cs;

  //==========================================================================
  // identifier word on global reset only
  always_ff @(posedge CORE_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      dev_id <= PCFGS_DEV_ID_DEF;
      ven_id <= PCFGS_VEN_ID_DEF;
    end
    else if (ID_LOAD_I)
    begin
      dev_id <= ID_DATA_I[31:16];
      ven_id <= ID_DATA_I[15:0];
    end
  end

  //==========================================================================
  // enables, cleared on pci reset
  always_ff @(posedge CORE_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      system_error_enable <= 1'b0;
      par_resp <= 1'b0;
    end
    else if (!PCI_NRST_I)
    begin
      system_error_enable <= 1'b0;
      par_resp <= 1'b0;
    end
    else
    begin
      // lanes are independent so a full-word write updates both enables
      if (wr_cs && CFG_ACC_I.be[1])
        system_error_enable <= CFG_ACC_I.wdata[PCFGS_BIT_SERREN];
      if (wr_cs && CFG_ACC_I.be[0])
        par_resp <= CFG_ACC_I.wdata[PCFGS_BIT_PARITY_RESPONSE_ENABLE];
    end
  end

  //==========================================================================
  // sticky status flags; a set in the clear cycle wins
  always_ff @(posedge CORE_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      dpe <= 1'b0;
      sserr <= 1'b0;
      rma <= 1'b0;
      rta <= 1'b0;
      sta <= 1'b0;
      mdp <= 1'b0;
    end
    else if (!PCI_NRST_I)
    begin
      dpe <= 1'b0;
      sserr <= 1'b0;
      rma <= 1'b0;
      rta <= 1'b0;
      sta <= 1'b0;
      mdp <= 1'b0;
    end
    else
    begin
      dpe <= (EVT_I.mst_data_perr || EVT_I.tgt_addr_perr || EVT_I.tgt_data_perr)
             || (dpe && !w1c(wr_cs, CFG_ACC_I.be, CFG_ACC_I.wdata, PCFGS_BIT_DPE));
      sserr <= (EVT_I.tgt_addr_perr && system_error_enable && par_resp)
               || (sserr && !w1c(wr_cs, CFG_ACC_I.be, CFG_ACC_I.wdata,
                                 PCFGS_BIT_SSERR));
      rma <= EVT_I.mst_abort
             || (rma && !w1c(wr_cs, CFG_ACC_I.be, CFG_ACC_I.wdata, PCFGS_BIT_RMA));
      rta <= EVT_I.mst_rx_tabort
             || (rta && !w1c(wr_cs, CFG_ACC_I.be, CFG_ACC_I.wdata, PCFGS_BIT_RTA));
      sta <= EVT_I.tgt_tx_tabort
             || (sta && !w1c(wr_cs, CFG_ACC_I.be, CFG_ACC_I.wdata, PCFGS_BIT_STA));
      mdp <= (par_resp && (EVT_I.mst_perr_own || EVT_I.mst_perr_tgt))
             || (mdp && !w1c(wr_cs, CFG_ACC_I.be, CFG_ACC_I.wdata, PCFGS_BIT_MDP));
    end
  end

  //==========================================================================
  // read word assembly; unlisted bits stay zero
  always_comb
  begin
    cs_word = 32'h0;
    cs_word[PCFGS_BIT_DPE] = dpe;
    cs_word[PCFGS_BIT_SSERR] = sserr;
    cs_word[PCFGS_BIT_RMA] = rma;
    cs_word[PCFGS_BIT_RTA] = rta;
    cs_word[PCFGS_BIT_STA] = sta;
    cs_word[PCFGS_BIT_SEL_HI:PCFGS_BIT_SEL_LO] = PCFGS_SEL_TIMING;
    cs_word[PCFGS_BIT_MDP] = mdp;
    cs_word[PCFGS_BIT_TBB] = PCFGS_TBB_VAL;
    cs_word[PCFGS_BIT_HS] = PCFGS_HS_VAL;
    cs_word[PCFGS_BIT_CAP] = PCFGS_CAP_VAL;
    cs_word[PCFGS_BIT_MBB] = PCFGS_MBB_VAL;
    cs_word[PCFGS_BIT_SERREN] = system_error_enable;
    cs_word[PCFGS_BIT_WAIT] = PCFGS_WAIT_VAL;
    cs_word[PCFGS_BIT_PARITY_RESPONSE_ENABLE] = par_resp;
    cs_word[PCFGS_BIT_SNOOP] = PCFGS_SNOOP_VAL;
    if (sel_id)
      next_rdata = {dev_id, ven_id};
    else if (sel_cs)
      next_rdata = cs_word;
    else
      next_rdata = 32'h0;
  end

  // read data registered one cycle after the read strobe
  always_ff @(posedge CORE_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
      CFG_RDATA_O <= 32'h0;
    else if (CFG_ACC_I.rd)
      CFG_RDATA_O <= next_rdata;
  end

  //==========================================================================
  // enables toward the pci pins; par generation is not gated here
  assign SYSTEM_ERROR_ENABLE_O = system_error_enable && par_resp;
  assign PERR_EN_O = par_resp;
  assign STAT_IRQ_O = {dpe, sserr, rma, rta, sta, mdp};
endmodule : pcfgs_top
`default_nettype wire

// ==== pkg/pcfgs_pkg.sv ====
// package of constants and carriers for the pci configuration id and status block
//==========================================================================
package pcfgs_pkg;
  //==========================================================================
  // register offsets
  localparam logic [11:0] PCFGS_OFS_IDENT = 12'h000;
  localparam logic [11:0] PCFGS_OFS_CMDSTAT = 12'h004;
  //==========================================================================
  // field positions in the command and status word
  localparam int PCFGS_BIT_DPE = 31;
  localparam int PCFGS_BIT_SSERR = 30;
  localparam int PCFGS_BIT_RMA = 29;
  localparam int PCFGS_BIT_RTA = 28;
  localparam int PCFGS_BIT_STA = 27;
  localparam int PCFGS_BIT_SEL_HI = 26;
  localparam int PCFGS_BIT_SEL_LO = 25;
  localparam int PCFGS_BIT_MDP = 24;
  localparam int PCFGS_BIT_TBB = 23;
  localparam int PCFGS_BIT_HS = 21;
  localparam int PCFGS_BIT_CAP = 20;
  localparam int PCFGS_BIT_MBB = 9;
  localparam int PCFGS_BIT_SERREN = 8;
  localparam int PCFGS_BIT_WAIT = 7;
  localparam int PCFGS_BIT_PARITY_RESPONSE_ENABLE = 6;
  localparam int PCFGS_BIT_SNOOP = 5;
  //==========================================================================
  // constant field values
  localparam logic [1:0] PCFGS_SEL_TIMING = 2'h1;
  localparam logic PCFGS_TBB_VAL = 1'h1;
  localparam logic PCFGS_HS_VAL = 1'h0;
  localparam logic PCFGS_CAP_VAL = 1'h1;
  localparam logic PCFGS_MBB_VAL = 1'h0;
  localparam logic PCFGS_WAIT_VAL = 1'h0;
  localparam logic PCFGS_SNOOP_VAL = 1'h0;
  // identifier defaults: arbitrary neutral values
  localparam logic [15:0] PCFGS_DEV_ID_DEF = 16'h1234;
  localparam logic [15:0] PCFGS_VEN_ID_DEF = 16'hABCD;
  //==========================================================================
  // event pulses from the pci master and target modules
  typedef struct packed {
    logic mst_data_perr;   // master saw a data parity error
    logic tgt_addr_perr;   // target saw an address parity error
    logic tgt_data_perr;   // target saw a data parity error
    logic mst_abort;       // master ended with master-abort
    logic mst_rx_tabort;   // master got target-abort
    logic tgt_tx_tabort;   // target signalled target-abort
    logic mst_perr_own;    // master asserts perr itself
    logic mst_perr_tgt;    // addressed target asserts perr
  } pcfgs_evt_t;
  // configuration access from the host side
  typedef struct packed {
    logic rd;
    logic wr;
    logic [11:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } pcfgs_acc_t;
endpackage : pcfgs_pkg

// ==== bench/pcfgs_chk.sv ====
// assertion checker for the configuration status block
`timescale 1ns/10ps
`default_nettype none
module pcfgs_chk
  import pcfgs_pkg::*;
(
  input wire logic CORE_CLK_I,         // clock
  input wire logic NRST_I,             // global reset
  input wire logic PCI_NRST_I,         // pci reset
  input wire pcfgs_acc_t CFG_ACC_I,    // access
  input wire pcfgs_evt_t EVT_I,        // events
  input wire logic [31:0] CFG_RDATA_O, // read data
  input wire logic SYSTEM_ERROR_ENABLE_O,          // serr gate
  input wire logic PERR_EN_O,          // perr gate
  input wire logic [5:0] STAT_IRQ_O    // flags
);
  default clocking @(posedge CORE_CLK_I);
  endclocking
  default disable iff (!NRST_I);
  //==========================================================================
  // steps: a status read, or an event that must land a flag one edge later
  sequence s_rd_cs;
    CFG_ACC_I.rd && CFG_ACC_I.addr == PCFGS_OFS_CMDSTAT;
  endsequence
  property p_set(ev, fl);
    ev && PCI_NRST_I |=> fl;
  endproperty
  a_dpe_set: assert property (p_set(|EVT_I[7:5], STAT_IRQ_O[5]))
    else $error("parity flag missed");
  a_rma_set: assert property (p_set(EVT_I.mst_abort, STAT_IRQ_O[3]))
    else $error("master abort flag missed");
  a_rta_set: assert property (p_set(EVT_I.mst_rx_tabort, STAT_IRQ_O[2]))
    else $error("received abort flag missed");
  a_sta_set: assert property (p_set(EVT_I.tgt_tx_tabort, STAT_IRQ_O[1]))
    else $error("signaled abort flag missed");
  a_serr_gate: assert property (SYSTEM_ERROR_ENABLE_O |-> PERR_EN_O)
    else $error("serr enabled without parity response");
  a_sserr_cause: assert property ($rose(STAT_IRQ_O[4]) |->
    $past(SYSTEM_ERROR_ENABLE_O && EVT_I.tgt_addr_perr)) else $error("system error flag unexplained");
  a_mdp_cause: assert property ($rose(STAT_IRQ_O[0]) |-> $past(PERR_EN_O &&
    (EVT_I.mst_perr_own || EVT_I.mst_perr_tgt || EVT_I.mst_data_perr)))
    else $error("master parity flag unexplained");
  a_read_const: assert property (s_rd_cs |=>
    CFG_RDATA_O[26:25] == PCFGS_SEL_TIMING && CFG_RDATA_O[23:20] == 4'h9
    && !CFG_RDATA_O[9] && !CFG_RDATA_O[7] && !CFG_RDATA_O[5]) else $error("fixed bits wrong");
endmodule : pcfgs_chk
bind pcfgs_top pcfgs_chk u_chk (.CORE_CLK_I, .NRST_I, .PCI_NRST_I, .CFG_ACC_I, .EVT_I,
  .CFG_RDATA_O, .SYSTEM_ERROR_ENABLE_O, .PERR_EN_O, .STAT_IRQ_O);
`default_nettype wire

// ==== bench/pcfgs_host.sv ====
// configuring host model issuing single-cycle accesses
`timescale 1ns/10ps
`default_nettype none
module pcfgs_host
  import pcfgs_pkg::*;
(
  input wire logic clk_i,          // clock
  input wire logic [31:0] rdata_i, // read data
  output var pcfgs_acc_t acc_o     // access
);
  initial acc_o = '0;
  //==========================================================================
  // one-cycle strobes; idle is all zero so no stale request lingers
  task automatic cfg_wr(input logic [11:0] a, input logic [3:0] be, input logic [31:0] v);
    @(posedge clk_i);
    acc_o <= '{rd: 1'b0, wr: 1'b1, addr: a, be: be, wdata: v};
    @(posedge clk_i);
    acc_o <= '0;
  endtask : cfg_wr
  task automatic cfg_rd(input logic [11:0] a, output logic [31:0] v);
    @(posedge clk_i);
    acc_o <= '{rd: 1'b1, wr: 1'b0, addr: a, be: 4'hF, wdata: 32'h0};
    @(posedge clk_i);
    acc_o <= '0;
    @(posedge clk_i);
    v = rdata_i;
  endtask : cfg_rd
endmodule : pcfgs_host
`default_nettype wire

// ==== bench/pcfgs_tb_top.sv ====
// self-checking bench for the configuration status block
`timescale 1ns/10ps
`default_nettype none
module pcfgs_tb_top
  import pcfgs_pkg::*;
();
  localparam logic [11:0] CS = PCFGS_OFS_CMDSTAT;
  localparam logic [31:0] FM = 32'hF900_0000;
  logic clk, nrst, pci_nrst, id_load, system_error_enable, perr_en;
  logic [31:0] id_data, rdata, d;
  logic [5:0] irq;
  pcfgs_evt_t evt;
  pcfgs_acc_t acc;
  int fails = 0;
  int comparisons = 0;
  pcfgs_top dut (.CORE_CLK_I(clk), .NRST_I(nrst), .PCI_NRST_I(pci_nrst), .CFG_ACC_I(acc),
    .EVT_I(evt), .ID_LOAD_I(id_load), .ID_DATA_I(id_data), .CFG_RDATA_O(rdata),
    .SYSTEM_ERROR_ENABLE_O(system_error_enable), .PERR_EN_O(perr_en), .STAT_IRQ_O(irq));
  pcfgs_host u_host (.clk_i(clk), .rdata_i(rdata), .acc_o(acc));
  // 40 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  //==========================================================================
  // helpers
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
      $display("Error at %0t: got %h expected %h", $time, g, e);
      fails++;
    end
  endtask : chk
  task automatic pulse(input logic [7:0] e);
    @(posedge clk);
    evt <= pcfgs_evt_t'(e);
    @(posedge clk);
    evt <= '0;
  endtask : pulse
  task automatic complete_run;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run
  //==========================================================================
  // fixed fields, unmapped space, identifier load and global reset
  task automatic t_ident;
    u_host.cfg_wr(CS, 4'hC, 32'hFFFF_0000);
    u_host.cfg_rd(CS, d);
    chk(d & 32'hFFFF_FFE0, 32'h0290_0000);
    u_host.cfg_wr(12'h008, 4'hF, 32'hFFFF_FFFF);
    u_host.cfg_rd(12'h008, d);
    chk(d, 32'h0);
    id_data <= 32'h5A5A_C3C3;
    id_load <= 1'b1;
    @(posedge clk);
    id_load <= 1'b0;
    u_host.cfg_rd(PCFGS_OFS_IDENT, d);
    chk(d, 32'h5A5A_C3C3);
    nrst <= 1'b0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    u_host.cfg_rd(PCFGS_OFS_IDENT, d);
    chk(d, {PCFGS_DEV_ID_DEF, PCFGS_VEN_ID_DEF});
    $display("t_ident done");
  endtask : t_ident
  // each event except mst_perr_own and mst_perr_tgt sets exactly its own flag, and write-one clears it
  task automatic t_flags;
    int fb[8] = '{0, 0, 27, 28, 29, 31, 31, 31};
    int ib[8] = '{0, 0, 1, 2, 3, 5, 5, 5};
    for (int i = 2; i < 8; i++)
    begin
      pulse(8'h01 << i);
      u_host.cfg_rd(CS, d);
      chk(d & FM, 32'h1 << fb[i]);
      chk(32'(irq), 32'h1 << ib[i]);
      u_host.cfg_wr(CS, 4'h8, 32'h1 << fb[i]);
      u_host.cfg_rd(CS, d);
      chk(d & FM, 32'h0);
    end
    $display("t_flags done");
  endtask : t_flags
  // enables gate the system error and master parity flags; pci reset clears
  task automatic t_parity;
    u_host.cfg_wr(CS, 4'h2, 32'h0000_0100);
    pulse(8'h42);
    chk(32'({system_error_enable, perr_en}), 32'h0);
    u_host.cfg_rd(CS, d);
    chk(d & FM, 32'h8000_0000);
    u_host.cfg_wr(CS, 4'hB, 32'h8000_0140);
    pulse(8'h41);
    chk(32'({system_error_enable, perr_en}), 32'h3);
    u_host.cfg_rd(CS, d);
    chk(d & FM, 32'hC100_0000);
    chk(32'(irq), 32'h31);
    pci_nrst <= 1'b0;
    @(posedge clk);
    pci_nrst <= 1'b1;
    u_host.cfg_rd(CS, d);
    chk(d & (FM | 32'h140), 32'h0);
    $display("t_parity done");
  endtask : t_parity
  //==========================================================================
  // main sequence, plus a watchdog so a hang still reaches the verdict
  initial
  begin
    {nrst, pci_nrst, id_load} = 3'h0;
    id_data = 32'h0;
    evt = '0;
    repeat (4) @(posedge clk);
    {nrst, pci_nrst} <= 2'h3;
    t_ident();
    t_flags();
    t_parity();
    complete_run();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    complete_run();
  end
endmodule : pcfgs_tb_top
`default_nettype wire
